//--- inc/xfd_pkg.sv
// Package with constants and carrier types for the instruction format decoder
package xfd_pkg;
	// ----------------------------------------
	// Prefix encodings
	// ----------------------------------------
	localparam logic [7:0] XFD_PFX_ES = 8'h26;
	localparam logic [7:0] XFD_PFX_CS = 8'h2e;
	localparam logic [7:0] XFD_PFX_SS = 8'h36;
	localparam logic [7:0] XFD_PFX_DS = 8'h3e;
	localparam logic [7:0] XFD_PFX_FS = 8'h64;
	localparam logic [7:0] XFD_PFX_GS = 8'h65;
	localparam logic [7:0] XFD_PFX_OPSZ = 8'h66;
	localparam logic [7:0] XFD_PFX_ADSZ = 8'h67;
	localparam logic [7:0] XFD_PFX_LOCK = 8'hf0;
	localparam logic [7:0] XFD_PFX_LOOP_NE = 8'hf2;
	localparam logic [7:0] XFD_PFX_LOOP_EQ = 8'hf3;
	// ----------------------------------------
	// Opcode encodings and field positions
	// ----------------------------------------
	localparam logic [7:0] XFD_OP_ESCAPE = 8'h0f;
	localparam logic [7:0] XFD_OP_GROUP_IMM = 8'h80;
	localparam int XFD_W_BIT = 0;
	localparam int XFD_D_BIT = 1;
	localparam int XFD_S_BIT = 1;
	localparam int XFD_MOD_HI = 7;
	localparam int XFD_MOD_LO = 6;
	localparam int XFD_REG_HI = 5;
	localparam int XFD_REG_LO = 3;
	localparam int XFD_RM_HI = 2;
	localparam int XFD_RM_LO = 0;
	localparam logic [1:0] XFD_MOD_REG = 2'h3;
	localparam logic [2:0] XFD_RM_SIB = 3'h4;
	localparam logic [3:0] XFD_MAX_LEN = 4'hf;
	localparam logic [15:0] XFD_GP_ERR_CODE = 16'h0000;
	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [2:0] {
		XFD_SEG_DEFAULT = 3'h0, XFD_SEG_ES = 3'h1, XFD_SEG_CS = 3'h2, XFD_SEG_SS = 3'h3,
		XFD_SEG_DS = 3'h4, XFD_SEG_FS = 3'h5, XFD_SEG_GS = 3'h6
	} xfd_seg_t;
	typedef enum logic [1:0] {
		XFD_SZ_8 = 2'h0, XFD_SZ_16 = 2'h1, XFD_SZ_32 = 2'h2, XFD_SZ_NONE = 2'h3
	} xfd_size_t;
	typedef enum logic [1:0] {
		XFD_REGK_GENERAL = 2'h0, XFD_REGK_SEG_WIDE = 2'h1, XFD_REGK_SEG_NARROW = 2'h2
	} xfd_regk_t;
	typedef enum logic [3:0] {
		XFD_ADDR_REG = 4'h0, XFD_ADDR_IND = 4'h1, XFD_ADDR_DISP8 = 4'h2,
		XFD_ADDR_DISPW = 4'h3, XFD_ADDR_DIRECT = 4'h4, XFD_ADDR_SIB = 4'h5,
		XFD_ADDR_SIB_D8 = 4'h6, XFD_ADDR_SIB_DW = 4'h7
	} xfd_addr_t;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		xfd_seg_t seg;
		logic op_inv;
		logic ad_inv;
		logic lock;
		logic loop_ne;
		logic loop_eq;
	} xfd_pfx_t;
	typedef struct packed {
		xfd_pfx_t pfx;
		logic two_byte;
		logic [7:0] opcode;
		logic group_imm;
		logic [2:0] group_sel;
		logic op32;
		logic ad32;
		xfd_size_t op_size;
		logic dir_to_reg;
		logic reg_in_opcode;
		logic [2:0] reg_field;
		xfd_regk_t reg_kind;
		xfd_addr_t addr_mode;
		logic [1:0] sib_scale;
		logic [2:0] sib_index;
		logic [2:0] sib_base;
		xfd_size_t imm_size;
		logic imm_sext;
		logic bus_hold;
		logic repeat_en;
	} xfd_dec_t;
	// Per-opcode attributes supplied by the core's opcode table
	typedef struct packed {
		logic has_w;
		logic has_d;
		logic has_s;
		logic has_modrm;
		logic reg_in_op;
		xfd_regk_t reg_kind;
		logic has_imm;
		logic is_string;
	} xfd_opattr_t;
endpackage

//--- logic/xfd_prefix_acc.sv
// Prefix accumulator: folds prefix bytes into order-free flags and a last-wins segment select
`timescale 1ns/1ps
module xfd_prefix_acc
	import xfd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic take,
	input wire logic [7:0] byte_in,
	output logic is_prefix,
	output xfd_pfx_t pfx
);
	xfd_pfx_t pfx_reg;
	xfd_pfx_t pfx_next;
	xfd_seg_t seg_hit;
	wire logic seg_is = (seg_hit != XFD_SEG_DEFAULT);

	// Segment prefix lookup
	always_comb begin
		unique case (byte_in)
			XFD_PFX_ES: seg_hit = XFD_SEG_ES;
			XFD_PFX_CS: seg_hit = XFD_SEG_CS;
			XFD_PFX_SS: seg_hit = XFD_SEG_SS;
			XFD_PFX_DS: seg_hit = XFD_SEG_DS;
			XFD_PFX_FS: seg_hit = XFD_SEG_FS;
			XFD_PFX_GS: seg_hit = XFD_SEG_GS;
			default: seg_hit = XFD_SEG_DEFAULT;
		endcase
	end

	assign is_prefix = seg_is || byte_in == XFD_PFX_OPSZ || byte_in == XFD_PFX_ADSZ ||
		byte_in == XFD_PFX_LOCK || byte_in == XFD_PFX_LOOP_NE || byte_in == XFD_PFX_LOOP_EQ;

	// Flags are set (ORed), so their order makes no difference; a later segment prefix replaces an earlier one
	always_comb begin
		pfx_next = pfx_reg;
		if (take && seg_is) begin
			pfx_next.seg = seg_hit;
		end
		pfx_next.op_inv = pfx_reg.op_inv | (take && byte_in == XFD_PFX_OPSZ);
		pfx_next.ad_inv = pfx_reg.ad_inv | (take && byte_in == XFD_PFX_ADSZ);
		pfx_next.lock = pfx_reg.lock | (take && byte_in == XFD_PFX_LOCK);
		pfx_next.loop_ne = pfx_reg.loop_ne | (take && byte_in == XFD_PFX_LOOP_NE);
		pfx_next.loop_eq = pfx_reg.loop_eq | (take && byte_in == XFD_PFX_LOOP_EQ);
	end

	// Cleared on reset and when a decode is handed over
	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			pfx_reg <= '0;
		end else begin
			pfx_reg <= pfx_next;
		end
	end

	assign pfx = pfx_reg;
endmodule

//--- logic/xfd_decoder.sv
// Instruction format decoder: prefixes, opcode, addressing bytes, immediate size
`timescale 1ns/1ps
module xfd_decoder
	import xfd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_32,
	input wire logic byte_valid,
	output logic byte_ready,
	input wire logic [7:0] byte_data,
	input wire xfd_opattr_t op_attr,
	output logic [7:0] attr_opcode,
	output logic attr_two_byte,
	input wire logic exec_busy,
	output logic dec_valid,
	input wire logic dec_ready,
	output xfd_dec_t dec,
	output logic [3:0] dec_len,
	output logic gp_fault,
	output logic [15:0] gp_err_code,
	output logic bus_hold
);
	// ----------------------------------------
	// State machine
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_PFX = 6'b000001,
		ST_OP2 = 6'b000010,
		ST_MODRM = 6'b000100,
		ST_SIB = 6'b001000,
		ST_REST = 6'b010000,
		ST_DONE = 6'b100000
	} xfd_st_t;

	xfd_st_t st_reg;
	xfd_st_t st_next;
	logic [3:0] len_reg;
	logic [3:0] len_next;
	logic [5:0] tail_reg;
	logic [5:0] tail_next;
	logic [7:0] op_reg;
	logic two_reg;
	logic [7:0] modrm_reg;
	logic [7:0] sib_reg;
	logic has_modrm_reg;
	logic has_sib_reg;
	xfd_opattr_t attr_reg;
	xfd_dec_t dec_reg;
	logic dec_valid_reg;
	logic fault_reg;
	logic hold_reg;

	wire logic take = byte_valid && byte_ready;
	wire logic in_pfx = (st_reg == ST_PFX);
	wire logic is_pfx;
	xfd_pfx_t pfx;

	// Accumulates prefix flags; cleared when a decode is handed over
	xfd_prefix_acc u_pfx (
		.clk(clk),
		.rst_n(rst_n),
		.clear(dec_valid_reg && dec_ready),
		.take(take && in_pfx && is_pfx),
		.byte_in(byte_data),
		.is_prefix(is_pfx),
		.pfx(pfx)
	);

	// ----------------------------------------
	// Size functions
	// ----------------------------------------
	// Bytes of displacement implied by the addressing fields
	function automatic logic [2:0] disp_bytes(input logic [1:0] md, input logic [2:0] rm,
		input logic [2:0] base, input logic a32);
		disp_bytes = 3'h0;
		if (md == 2'h1) begin
			disp_bytes = 3'h1;
		end else if (md == 2'h2) begin
			disp_bytes = a32 ? 3'h4 : 3'h2;
		end else if (md == 2'h0) begin
			if (a32 && rm == 3'h5) begin
				disp_bytes = 3'h4;
			end else if (a32 && rm == XFD_RM_SIB && base == 3'h5) begin
				disp_bytes = 3'h4;
			end else if (!a32 && rm == 3'h6) begin
				disp_bytes = 3'h2;
			end
		end
	endfunction

	// Bytes of immediate given size code
	function automatic logic [2:0] imm_bytes(input xfd_size_t sz);
		unique case (sz)
			XFD_SZ_8: imm_bytes = 3'h1;
			XFD_SZ_16: imm_bytes = 3'h2;
			XFD_SZ_32: imm_bytes = 3'h4;
			default: imm_bytes = 3'h0;
		endcase
	endfunction

	// ----------------------------------------
	// Attribute decode of the captured bytes
	// ----------------------------------------
	// Default size comes from code segment, inverted by a prefix
	wire logic op32 = cs_32 ^ pfx.op_inv;
	wire logic ad32 = cs_32 ^ pfx.ad_inv;
	// While the addressing byte is taken the table entry is live and its copy is not loaded yet
	wire xfd_opattr_t attr_cur = (st_reg == ST_MODRM) ? op_attr : attr_reg;
	wire logic w_bit = attr_cur.has_w ? op_reg[XFD_W_BIT] : 1'b1;
	wire xfd_size_t full_sz = op32 ? XFD_SZ_32 : XFD_SZ_16;
	wire xfd_size_t op_sz = w_bit ? full_sz : XFD_SZ_8;
	wire logic s_bit = attr_cur.has_s && op_reg[XFD_S_BIT];
	// Byte-wide sign-extended immediate, else operand-sized
	wire xfd_size_t imm_sz = !attr_cur.has_imm ? XFD_SZ_NONE :
		(s_bit ? XFD_SZ_8 : op_sz);
	wire logic [1:0] md = modrm_reg[XFD_MOD_HI:XFD_MOD_LO];
	wire logic [2:0] rm = modrm_reg[XFD_RM_HI:XFD_RM_LO];
	wire logic want_sib = ad32 && md != XFD_MOD_REG && rm == XFD_RM_SIB;
	wire logic [2:0] dsp = disp_bytes(byte_data[XFD_MOD_HI:XFD_MOD_LO], byte_data[XFD_RM_HI:XFD_RM_LO],
		3'h0, ad32);
	wire logic [2:0] dsp_sib = disp_bytes(md, rm, byte_data[2:0], ad32);
	wire logic [2:0] immb = imm_bytes(imm_sz);

	// Addressing mode from form and locator fields together
	xfd_addr_t amode;
	always_comb begin
		amode = XFD_ADDR_REG;
		if (!has_modrm_reg || md == XFD_MOD_REG) begin
			amode = XFD_ADDR_REG;
		end else if (want_sib) begin
			amode = (md == 2'h0) ? XFD_ADDR_SIB : ((md == 2'h1) ? XFD_ADDR_SIB_D8 : XFD_ADDR_SIB_DW);
		end else if (md == 2'h0) begin
			amode = ((ad32 && rm == 3'h5) || (!ad32 && rm == 3'h6)) ? XFD_ADDR_DIRECT : XFD_ADDR_IND;
		end else begin
			amode = (md == 2'h1) ? XFD_ADDR_DISP8 : XFD_ADDR_DISPW;
		end
	end

	// Record assembled at the end of the instruction
	xfd_dec_t dec_build;
	always_comb begin
		dec_build = '0;
		dec_build.pfx = pfx;
		dec_build.two_byte = two_reg;
		dec_build.opcode = op_reg;
		dec_build.group_imm = !two_reg && op_reg == XFD_OP_GROUP_IMM;
		dec_build.group_sel = modrm_reg[XFD_REG_HI:XFD_REG_LO];
		dec_build.op32 = op32;
		dec_build.ad32 = ad32;
		dec_build.op_size = op_sz;
		dec_build.dir_to_reg = attr_reg.has_d ? op_reg[XFD_D_BIT] : 1'b0;
		dec_build.reg_in_opcode = attr_reg.reg_in_op;
		// Register field from the opcode's low bits or the addressing byte
		dec_build.reg_field = attr_reg.reg_in_op ? op_reg[2:0] : modrm_reg[XFD_REG_HI:XFD_REG_LO];
		dec_build.reg_kind = attr_reg.reg_kind;
		dec_build.addr_mode = amode;
		dec_build.sib_scale = has_sib_reg ? sib_reg[7:6] : 2'h0;
		dec_build.sib_index = has_sib_reg ? sib_reg[5:3] : 3'h0;
		dec_build.sib_base = has_sib_reg ? sib_reg[2:0] : 3'h0;
		dec_build.imm_size = imm_sz;
		dec_build.imm_sext = s_bit && imm_sz == XFD_SZ_8 && op_sz != XFD_SZ_8;
		dec_build.bus_hold = pfx.lock;
		dec_build.repeat_en = attr_reg.is_string && (pfx.loop_ne || pfx.loop_eq);
	end

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	// Each taken byte counts; the sixteenth byte is taken, dropped and faulted
	wire logic over = take && len_reg == XFD_MAX_LEN;
	// No byte is taken while the tail is being sized or is already used up, else it would be lost
	wire logic pause_take = (st_reg == ST_MODRM && !op_attr.has_modrm) || (st_reg == ST_REST && tail_reg == 6'h0);
	assign byte_ready = !dec_valid_reg && !fault_reg && st_reg != ST_DONE && !pause_take;

	always_comb begin
		st_next = st_reg;
		len_next = len_reg;
		tail_next = tail_reg;
		if (take && !over) begin
			len_next = len_reg + 4'h1;
		end
		unique case (st_reg)
			ST_PFX: begin
				if (take && !over && !is_pfx) begin
					st_next = (byte_data == XFD_OP_ESCAPE) ? ST_OP2 : ST_MODRM;
				end
			end
			ST_OP2: begin
				if (take && !over) begin
					st_next = ST_MODRM;
				end
			end
			ST_MODRM: begin
				// Attributes for the opcode are valid this cycle
				if (!op_attr.has_modrm) begin
					st_next = ST_REST;
					tail_next = {3'h0, imm_bytes(op_attr.has_imm ?
						(op_attr.has_s && op_reg[XFD_S_BIT] ? XFD_SZ_8 :
						((!op_attr.has_w || op_reg[XFD_W_BIT]) ? full_sz : XFD_SZ_8)) : XFD_SZ_NONE)};
				end else if (take && !over) begin
					st_next = (ad32 && byte_data[7:6] != XFD_MOD_REG && byte_data[2:0] == XFD_RM_SIB) ?
						ST_SIB : ST_REST;
					tail_next = (byte_data[7:6] == XFD_MOD_REG) ? {3'h0, immb} : {3'h0, dsp} + {3'h0, immb};
				end
			end
			ST_SIB: begin
				if (take && !over) begin
					st_next = ST_REST;
					tail_next = {3'h0, dsp_sib} + {3'h0, immb};
				end
			end
			ST_REST: begin
				if (tail_reg == 6'h0) begin
					st_next = ST_DONE;
				end else if (take && !over) begin
					tail_next = tail_reg - 6'h1;
				end
			end
			ST_DONE: begin
				if (dec_valid_reg && dec_ready) begin
					st_next = ST_PFX;
					len_next = 4'h0;
				end
			end
			default: st_next = ST_PFX;
		endcase
	end

	// State, length and tail count
	always_ff @(posedge clk) begin
		if (!rst_n || fault_reg) begin
			st_reg <= ST_PFX;
			len_reg <= 4'h0;
			tail_reg <= 6'h0;
		end else begin
			st_reg <= st_next;
			len_reg <= len_next;
			tail_reg <= tail_next;
		end
	end

	// Opcode and addressing bytes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			op_reg <= 8'h00;
			two_reg <= 1'b0;
			modrm_reg <= 8'h00;
			sib_reg <= 8'h00;
			has_modrm_reg <= 1'b0;
			has_sib_reg <= 1'b0;
			attr_reg <= '0;
		end else if (take && !over) begin
			if (in_pfx && !is_pfx) begin
				op_reg <= byte_data;
				two_reg <= 1'b0;
				has_modrm_reg <= 1'b0;
				has_sib_reg <= 1'b0;
				modrm_reg <= 8'h00;
			end else if (st_reg == ST_OP2) begin
				op_reg <= byte_data;
				two_reg <= 1'b1;
			end else if (st_reg == ST_MODRM) begin
				modrm_reg <= byte_data;
				has_modrm_reg <= op_attr.has_modrm;
				attr_reg <= op_attr;
			end else if (st_reg == ST_SIB) begin
				sib_reg <= byte_data;
				has_sib_reg <= 1'b1;
			end
		end else if (st_reg == ST_MODRM && !op_attr.has_modrm) begin
			attr_reg <= op_attr;
		end
	end

	// Output record, fault and bus hold
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dec_reg <= '0;
			dec_valid_reg <= 1'b0;
			fault_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			fault_reg <= over;
			if (st_reg == ST_DONE && !dec_valid_reg) begin
				dec_reg <= dec_build;
				dec_valid_reg <= 1'b1;
			end else if (dec_valid_reg && dec_ready) begin
				dec_valid_reg <= 1'b0;
			end
			// Held from hand-over until execution finishes
			if (dec_valid_reg && dec_ready) begin
				hold_reg <= dec_reg.bus_hold;
			end else if (!exec_busy) begin
				hold_reg <= 1'b0;
			end
		end
	end

	assign attr_opcode = op_reg;
	assign attr_two_byte = two_reg;
	assign dec = dec_reg;
	assign dec_valid = dec_valid_reg;
	assign dec_len = len_reg;
	assign gp_fault = fault_reg;
	assign gp_err_code = XFD_GP_ERR_CODE;
	assign bus_hold = hold_reg;
endmodule

//--- bench/xfd_prefetch_model.sv
// Prefetch unit model: byte source and opcode attribute table
`timescale 1ns/1ps
module xfd_prefetch_model
	import xfd_pkg::*;
(
	input wire logic clk,
	input wire logic byte_ready,
	input wire logic [7:0] attr_opcode,
	input wire logic attr_two_byte,
	output logic byte_valid,
	output logic [7:0] byte_data,
	output xfd_opattr_t op_attr
);
	logic [7:0] q[$];
	logic valid_reg = 1'b0;
	logic [7:0] data_reg = 8'h00;
	// A byte stands until taken; idle data is inverted so stale bytes never look valid
	always @(posedge clk) begin
		if (valid_reg && byte_ready)
			q.delete(0);
		valid_reg <= (q.size() != 0);
		data_reg <= (q.size() != 0) ? q[0] : ~data_reg;
	end
	assign byte_valid = valid_reg;
	assign byte_data = data_reg;
	// Small opcode table: w, d, s, modrm, reg in opcode, reg kind, imm, string
	function automatic xfd_opattr_t attr_of(input logic [8:0] key);
		casez (key)
			9'b0_0000_00??: return '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, XFD_REGK_GENERAL, 1'b0, 1'b0};
			9'b0_0000_0101: return '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, XFD_REGK_GENERAL, 1'b1, 1'b0};
			9'b0_000?_?110: return '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, XFD_REGK_SEG_NARROW, 1'b0, 1'b0};
			9'b0_1000_00??: return '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, XFD_REGK_GENERAL, 1'b1, 1'b0};
			9'b0_1000_1100: return '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, XFD_REGK_SEG_WIDE, 1'b0, 1'b0};
			9'b0_1010_010?: return '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, XFD_REGK_GENERAL, 1'b0, 1'b1};
			9'b1_1100_1???: return '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, XFD_REGK_GENERAL, 1'b0, 1'b0};
			default: return '0;
		endcase
	endfunction
	assign op_attr = attr_of({attr_two_byte, attr_opcode});
endmodule

//--- bench/xfd_decoder_sva.sv
// Port checker for the instruction format decoder
`timescale 1ns/1ps
module xfd_decoder_chk
	import xfd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_32,
	input wire logic byte_valid,
	input wire logic byte_ready,
	input wire logic exec_busy,
	input wire logic dec_valid,
	input wire logic dec_ready,
	input wire xfd_dec_t dec,
	input wire logic [3:0] dec_len,
	input wire logic gp_fault,
	input wire logic [15:0] gp_err_code,
	input wire logic bus_hold
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence s_take16;
		byte_valid && byte_ready && dec_len == 4'hf;
	endsequence
	sequence s_lock_out;
		dec_valid && dec_ready && dec.pfx.lock;
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_GP_AFTER16: assert property (s_take16 |=> gp_fault) else $error("no fault on byte sixteen");
	AST_GP_PULSE: assert property (gp_fault |=> !gp_fault) else $error("fault pulse too long");
	AST_GP_CODE: assert property (gp_err_code == XFD_GP_ERR_CODE) else $error("fault code not zero");
	AST_OP32: assert property (dec_valid |-> dec.op32 == (cs_32 ^ dec.pfx.op_inv)) else $error("op size");
	AST_AD32: assert property (dec_valid |-> dec.ad32 == (cs_32 ^ dec.pfx.ad_inv)) else $error("addr size");
	AST_SEXT: assert property (dec_valid && dec.imm_sext |-> dec.imm_size == XFD_SZ_8) else $error("sext imm");
	AST_IMMSZ: assert property (dec_valid && !dec.imm_sext && dec.imm_size != XFD_SZ_NONE
		|-> dec.imm_size == dec.op_size) else $error("imm size");
	AST_HOLD_ON: assert property (s_lock_out ##1 exec_busy [*2] |-> bus_hold) else $error("bus hold missing");
	AST_HOLD_OFF: assert property (!exec_busy |=> !bus_hold) else $error("bus hold stuck");
	AST_REP: assert property (dec_valid && dec.repeat_en |-> dec.pfx.loop_ne || dec.pfx.loop_eq) else $error("rep");
	AST_GROUP: assert property (dec_valid && !dec.two_byte && dec.opcode == XFD_OP_GROUP_IMM
		|-> dec.group_imm) else $error("group");
endmodule
bind xfd_decoder xfd_decoder_chk u_chk (.clk(clk), .rst_n(rst_n), .cs_32(cs_32), .byte_valid(byte_valid),
	.byte_ready(byte_ready), .exec_busy(exec_busy), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec(dec),
	.dec_len(dec_len), .gp_fault(gp_fault), .gp_err_code(gp_err_code), .bus_hold(bus_hold));

//--- bench/testbench.sv
// Self-checking bench for the instruction format decoder
`timescale 1ns/1ps
module testbench
	import xfd_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_32 = 1'b0;
	logic exec_busy = 1'b0;
	logic dec_ready = 1'b1;
	logic byte_valid, byte_ready, attr_two_byte, dec_valid, gp_fault, bus_hold;
	logic [7:0] byte_data, attr_opcode;
	logic [3:0] dec_len;
	logic [15:0] gp_err_code;
	xfd_opattr_t op_attr;
	xfd_dec_t dec, rec, first;
	int n_fail = 0;
	int compares = 0;
	always #2.5 clk = ~clk;
	xfd_decoder DUT (.clk(clk), .rst_n(rst_n), .cs_32(cs_32), .byte_valid(byte_valid), .byte_ready(byte_ready),
		.byte_data(byte_data), .op_attr(op_attr), .attr_opcode(attr_opcode), .attr_two_byte(attr_two_byte),
		.exec_busy(exec_busy), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec(dec), .dec_len(dec_len),
		.gp_fault(gp_fault), .gp_err_code(gp_err_code), .bus_hold(bus_hold));
	xfd_prefetch_model pf (.clk(clk), .byte_ready(byte_ready), .attr_opcode(attr_opcode),
		.attr_two_byte(attr_two_byte), .byte_valid(byte_valid), .byte_data(byte_data), .op_attr(op_attr));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("Compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Feed one instruction; the record is taken when valid, dec_ready hands it over
	task automatic decode(input logic [7:0] b[$]);
		int i;
		foreach (b[k])
			pf.q.push_back(b[k]);
		for (i = 0; i < 80 && dec_valid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 80) begin
			n_fail++;
			wrap_up();
		end
		rec = dec;
		@(posedge clk);
		#1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_prefix;
		decode({8'h66, 8'h26, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04});
		first = rec;
		chk("seg", XFD_SEG_ES, rec.pfx.seg);
		chk("op_size", XFD_SZ_32, rec.op_size);
		chk("imm_size", XFD_SZ_32, rec.imm_size);
		decode({8'h26, 8'h66, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04});
		chk("order", 1'b1, rec === first);
	endtask
	task automatic t_segs;
		logic [7:0] p[6] = '{XFD_PFX_ES, XFD_PFX_CS, XFD_PFX_SS, XFD_PFX_DS, XFD_PFX_FS, XFD_PFX_GS};
		xfd_seg_t s[6] = '{XFD_SEG_ES, XFD_SEG_CS, XFD_SEG_SS, XFD_SEG_DS, XFD_SEG_FS, XFD_SEG_GS};
		for (int i = 0; i < 6; i++) begin
			decode({p[i], 8'h90});
			chk("seg", s[i], rec.pfx.seg);
		end
	endtask
	task automatic t_group;
		@(posedge clk);
		cs_32 <= 1'b1;
		decode({8'h80, 8'hf9, 8'h7f});
		chk("group", 4'hf, {rec.group_imm, rec.group_sel});
		chk("addr", XFD_ADDR_REG, rec.addr_mode);
		chk("imm8", XFD_SZ_8, rec.imm_size);
		decode({8'h83, 8'hc0, 8'hfb});
		chk("sext", 4'h9, {rec.imm_sext, rec.imm_size, rec.op_size == XFD_SZ_32});
		decode({8'h66, 8'h81, 8'hc0, 8'h01, 8'h02});
		chk("imm16", XFD_SZ_16, rec.imm_size);
		@(posedge clk);
		cs_32 <= 1'b0;
	endtask
	task automatic t_modrm;
		decode({8'h67, 8'h03, 8'h44, 8'h8a, 8'h10});
		chk("ad32", 1'b1, rec.ad32);
		chk("addr", XFD_ADDR_SIB_D8, rec.addr_mode);
		chk("sib", 8'h8a, {rec.sib_scale, rec.sib_index, rec.sib_base});
		chk("dir_reg", 4'h8, {rec.dir_to_reg, rec.reg_field});
		decode({8'h00, 8'hd8});
		chk("w0", XFD_SZ_8, rec.op_size);
		chk("dir_reg", 4'h3, {rec.dir_to_reg, rec.reg_field});
		decode({8'h01, 8'h06, 8'h34, 8'h12});
		chk("addr", XFD_ADDR_DIRECT, rec.addr_mode);
	endtask
	task automatic t_kinds;
		decode({8'h8c, 8'hd8});
		chk("kind", XFD_REGK_SEG_WIDE, rec.reg_kind);
		decode({8'h1e});
		chk("kind", XFD_REGK_SEG_NARROW, rec.reg_kind);
		decode({XFD_OP_ESCAPE, 8'hc9});
		chk("twobyte", 5'h19, {rec.two_byte, rec.reg_in_opcode, rec.reg_field});
	endtask
	task automatic t_repeat;
		decode({XFD_PFX_LOOP_EQ, 8'ha5});
		chk("rep_eq", 2'h3, {rec.repeat_en, rec.pfx.loop_eq});
		decode({XFD_PFX_LOOP_NE, 8'ha4});
		chk("rep_ne", 2'h3, {rec.repeat_en, rec.pfx.loop_ne});
		decode({XFD_PFX_LOOP_EQ, 8'h90});
		chk("rep_off", 1'b0, rec.repeat_en);
	endtask
	task automatic t_lock;
		@(posedge clk);
		exec_busy <= 1'b1;
		decode({XFD_PFX_LOCK, 8'h01, 8'h00});
		chk("addr", XFD_ADDR_IND, rec.addr_mode);
		@(posedge clk);
		#1;
		chk("bus_hold", 1'b1, bus_hold);
		@(posedge clk);
		exec_busy <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("bus_hold", 1'b0, bus_hold);
	endtask
	task automatic t_long;
		logic seen;
		seen = 1'b0;
		repeat (14) pf.q.push_back(XFD_PFX_OPSZ);
		decode({8'h90});
		chk("len15", 1'b1, rec.pfx.op_inv);
		repeat (16) pf.q.push_back(XFD_PFX_OPSZ);
		repeat (40) begin
			@(posedge clk);
			#1;
			seen |= (gp_fault === 1'b1);
		end
		chk("gp_fault", 1'b1, seen);
		chk("gp_code", XFD_GP_ERR_CODE, gp_err_code);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("reset", 2'h2, {byte_ready, dec_valid});
		t_prefix();
		t_segs();
		t_group();
		t_modrm();
		t_kinds();
		t_repeat();
		t_lock();
		t_long();
		wrap_up();
	end
endmodule
